/* chp_defs.svh */
// Constants of the compass host command port: timing, characters, fields, offsets.
// Assumes a 25 MHz core clock on both ends of the link.
`ifndef CHP_DEFS_SVH
`define CHP_DEFS_SVH
// ==========================================================================
// Timing
`define CHP_CLK_PERIOD_NS 40
`define CHP_T_CS_MIN_NS   20000
`define CHP_T_SCK_HIGH_NS 16000
`define CHP_T_SCK_LOW_NS  22000
`define CHP_T_GAP_NS      50000
`define CHP_CS_MIN_CYC    ((`CHP_T_CS_MIN_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
`define CHP_SCK_HIGH_CYC  (`CHP_T_SCK_HIGH_NS / `CHP_CLK_PERIOD_NS)
`define CHP_SCK_LOW_CYC   (`CHP_T_SCK_LOW_NS / `CHP_CLK_PERIOD_NS)
`define CHP_GAP_CYC       ((`CHP_T_GAP_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
// ==========================================================================
// Characters
`define CHP_CH_START 8'h73
`define CHP_CH_ERR   8'h65
`define CHP_CH_HUP   8'h48
`define CHP_CH_HLO   8'h68
`define CHP_CH_HASH  8'h23
`define CHP_CH_D     8'h44
`define CHP_CH_EQ    8'h3d
`define CHP_CH_I     8'h49
`define CHP_CH_CR    8'h0d
`define CHP_CH_LF    8'h0a
`define CHP_CH_ZERO  8'h30
// ==========================================================================
// Configuration word fields
`define CHP_CFG_SPLIT_BIT 10
`define CHP_CFG_ALARM_BIT 9
`define CHP_CFG_WARN_BIT  8
`define CHP_CFG_ONE_BIT   5
`define CHP_CFG_HOUT_BIT  3
`define CHP_CFG_MOUT_BIT  1
// ==========================================================================
// Controller registers (byte offsets)
`define CHP_REG_CMD      8'h00
`define CHP_REG_STATUS   8'h04
`define CHP_REG_DATA     8'h08
`define CHP_REG_IRQ_STAT 8'h0c
`define CHP_REG_IRQ_MASK 8'h10
`define CHP_IRQ_DONE_BIT 0
`define CHP_IRQ_ERR_BIT  1
`define CHP_RESP_OKAY    2'h0
`define CHP_RESP_SLVERR  2'h2
`endif

/* chp_pkg.sv */
// Types shared by both ends of the compass host command port.
// Assumes chp_defs.svh for the character codes.
`include "chp_defs.svh"
package chp_pkg;
  // ==========================================================================
  // State machines
  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_LOW  = 4'h2,
    DEV_HIGH = 4'h4,
    DEV_DONE = 4'h8
  } chp_dev_st_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'h1,
    HST_RUN  = 3'h2,
    HST_END  = 3'h4
  } chp_hst_st_t;

  // ==========================================================================
  // Whole state of each end
  typedef struct packed {
    chp_dev_st_t st;
    logic [10:0] cnt;
    logic [2:0]  bitn;
    logic [1:0]  byten;
    logic        last;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [15:0] head;
    logic        sck;
    logic        sdo;
    logic [1:0]  cs_sync;
    logic [1:0]  sdi_sync;
    logic        warn;
    logic        alarm;
    logic [15:0] cfg;
    logic        rp_busy;
    logic        rp_inv;
    logic        rp_lead;
    logic [3:0]  rp_idx;
    logic [15:0] rp_val;
    logic [7:0]  rp_data;
    logic        rp_valid;
  } chp_dev_state_t;

  typedef struct packed {
    chp_hst_st_t st;
    logic [7:0]  cmd_sh;
    logic        is_head;
    logic [7:0]  rx;
    logic [2:0]  bitn;
    logic [1:0]  byten;
    logic [7:0]  echo;
    logic [15:0] data;
    logic [1:0]  sck_sync;
    logic        sck_prev;
    logic [1:0]  sdo_sync;
    logic        cs_n;
    logic        sdi;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } chp_hst_state_t;

  // Heading readout is asked for by either case of the letter
  function automatic logic chp_is_heading(input logic [7:0] c);
    return (c == `CHP_CH_HUP) || (c == `CHP_CH_HLO);
  endfunction
endpackage

/* chp_link_if.sv */
// Serial link between the compass port and its host controller.
// Assumes both ends sit on their own core clocks; the link is sampled, not clocked.
`timescale 1ns/10ps
interface chp_link_if;
  logic cs_n;
  logic sdi;
  logic sck;
  logic sdo;

  // Compass end makes the clock and the data out
  modport dev  (input cs_n, input sdi, output sck, output sdo);
  // Host end owns chip select and the command line
  modport host (output cs_n, output sdi, input sck, input sdo);
endinterface

/* chp_dev.sv */
// Compass end of the host command port: serial heading readout and ASCII replies.
// Assumes cs_n and sdi come from another clock domain; user inputs are on clock_i.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "chp_defs.svh"

// Operation
// - Configuration query reports 16-bit word in decimal
// - Bit 10 shows separate filter selection
// - Bit 9 sticks after below minus twenty
// - Bit 8 sticks after below minus ten
// - Bit 3 shows heading output selected
// - Bit 1 shows magnetometer output selected
// - Data reply: prefix, value, CR LF
// - Invalid command gets invalid reply, CR LF
// - Clock idles low, change after falling
// - Device drives clock and data out
// - Host holds chip select low twenty microseconds
// - Device sends s while receiving command
// - Valid command: send data, end session
// - Invalid command: send e, end session
// - Heading command: two bytes, MSB first
// - Clock high 16 us, low 22 us
// - Fifty microsecond gap between bytes
module chp_dev (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Link to the host
  chp_link_if.dev          link,
  // Measurement and mode inputs
  input  wire logic [11:0] heading_i,
  input  wire logic        separate_filter_select_i,
  input  wire logic        temp_below_m10_i,
  input  wire logic        temp_below_m20_i,
  input  wire logic        heading_out_sel_i,
  input  wire logic        mag_out_sel_i,
  // Command reply stream
  input  wire logic        configuration_query_i,
  input  wire logic        invalid_cmd_i,
  input  wire logic        reply_ready_i,
  output logic      [7:0]  reply_data_o,
  output logic             reply_valid_o,
  output logic             reply_busy_o,
  output logic      [15:0] config_status_o
);
  chp_pkg::chp_dev_state_t state_ff;
  chp_pkg::chp_dev_state_t nxt_state;

  // Character of the reply at a given position; positions 3..7 are the digits
  function automatic logic [7:0] reply_char(input logic [3:0] idx, input logic inv, input logic [15:0] v);
    logic [15:0] d;
    d = 16'h0000;
    unique case (idx)
      4'h3: d = v / 16'd10000;
      4'h4: d = (v / 16'd1000) % 16'd10;
      4'h5: d = (v / 16'd100) % 16'd10;
      4'h6: d = (v / 16'd10) % 16'd10;
      4'h7: d = v % 16'd10;
      default: d = 16'h0000;
    endcase
    unique case (idx)
      4'h0: reply_char = `CHP_CH_HASH;
      4'h1: reply_char = inv ? `CHP_CH_I : `CHP_CH_D;
      4'h2: reply_char = `CHP_CH_EQ;
      4'h8: reply_char = `CHP_CH_CR;
      4'h9: reply_char = `CHP_CH_LF;
      default: reply_char = `CHP_CH_ZERO + d[7:0];
    endcase
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic cs_n_s;
    logic sdi_s;
    logic [10:0] low_lim;
    logic [7:0] nb;
    logic [7:0] ch;
    nxt_state = state_ff;
    // Second synchroniser stage is the only one the logic reads
    cs_n_s = state_ff.cs_sync[1];
    sdi_s = state_ff.sdi_sync[1];
    nxt_state.cs_sync = {state_ff.cs_sync[0], link.cs_n};
    nxt_state.sdi_sync = {state_ff.sdi_sync[0], link.sdi};
    nb = 8'h00;
    ch = 8'h00;
    low_lim = (state_ff.bitn == 3'h0 && state_ff.byten != 2'h0) ? 11'(`CHP_GAP_CYC) : 11'(`CHP_SCK_LOW_CYC);

    // Temperature flags hold for the session: only reset clears them
    // Sticky cold warning
    if (temp_below_m10_i) begin
      nxt_state.warn = 1'b1;
    end
    if (temp_below_m20_i) begin
      nxt_state.alarm = 1'b1;
    end
    nxt_state.cfg = 16'h0000;
    nxt_state.cfg[`CHP_CFG_SPLIT_BIT] = separate_filter_select_i;
    nxt_state.cfg[`CHP_CFG_ALARM_BIT] = state_ff.alarm;
    nxt_state.cfg[`CHP_CFG_WARN_BIT] = state_ff.warn;
    nxt_state.cfg[`CHP_CFG_ONE_BIT] = 1'b1;
    nxt_state.cfg[`CHP_CFG_HOUT_BIT] = heading_out_sel_i;
    nxt_state.cfg[`CHP_CFG_MOUT_BIT] = mag_out_sel_i;

    // Serial session engine
    unique case (state_ff.st)
      chp_pkg::DEV_IDLE: begin
        nxt_state.sck = 1'b0;
        nxt_state.sdo = 1'b0;
        if (!cs_n_s) begin
          nxt_state.cnt = state_ff.cnt + 11'h001;
          // Session opens after minimum select time
          if (state_ff.cnt == 11'(`CHP_CS_MIN_CYC - 1)) begin
            ch = `CHP_CH_START;
            nxt_state.sdo = ch[7];
            nxt_state.tx = {ch[6:0], 1'b0};
            nxt_state.bitn = 3'h0;
            nxt_state.byten = 2'h0;
            nxt_state.last = 1'b0;
            nxt_state.head = {4'h0, heading_i};
            nxt_state.cnt = 11'h000;
            nxt_state.st = chp_pkg::DEV_LOW;
          end
        end else begin
          nxt_state.cnt = 11'h000;
        end
      end
      chp_pkg::DEV_LOW: begin
        nxt_state.cnt = state_ff.cnt + 11'h001;
        if (state_ff.cnt == low_lim - 11'h001) begin
          nxt_state.cnt = 11'h000;
          nxt_state.sck = 1'b1;
          // Sample command bit at rising edge
          nxt_state.rx = {state_ff.rx[6:0], sdi_s};
          nxt_state.st = chp_pkg::DEV_HIGH;
        end
      end
      chp_pkg::DEV_HIGH: begin
        nxt_state.cnt = state_ff.cnt + 11'h001;
        if (state_ff.cnt == 11'(`CHP_SCK_HIGH_CYC - 1)) begin
          nxt_state.cnt = 11'h000;
          nxt_state.sck = 1'b0;
          nxt_state.st = chp_pkg::DEV_LOW;
          if (state_ff.bitn != 3'h7) begin
            // New bit right after falling edge
            nxt_state.bitn = state_ff.bitn + 3'h1;
            nxt_state.sdo = state_ff.tx[7];
            nxt_state.tx = {state_ff.tx[6:0], 1'b0};
          end else if (state_ff.last) begin
            nxt_state.sdo = 1'b0;
            nxt_state.st = chp_pkg::DEV_DONE;
          end else begin
            nxt_state.bitn = 3'h0;
            nxt_state.byten = state_ff.byten + 2'h1;
            if (state_ff.byten == 2'h0) begin
              if (chp_pkg::chp_is_heading(state_ff.rx)) begin
                nb = state_ff.head[15:8];
                nxt_state.last = 1'b0;
              end else begin
                nb = `CHP_CH_ERR;
                nxt_state.last = 1'b1;
              end
            end else begin
              nb = state_ff.head[7:0];
              nxt_state.last = 1'b1;
            end
            nxt_state.sdo = nb[7];
            nxt_state.tx = {nb[6:0], 1'b0};
          end
        end
      end
      chp_pkg::DEV_DONE: begin
        nxt_state.sck = 1'b0;
        nxt_state.sdo = 1'b0;
      end
      default: nxt_state.st = chp_pkg::DEV_IDLE;
    endcase
    // Released select ends any session and rearms
    if (cs_n_s && state_ff.st != chp_pkg::DEV_IDLE) begin
      nxt_state.st = chp_pkg::DEV_IDLE;
      nxt_state.sck = 1'b0;
      nxt_state.sdo = 1'b0;
      nxt_state.cnt = 11'h000;
    end

    // Reply stream; a request while one is running is dropped
    if (!state_ff.rp_busy) begin
      if (configuration_query_i || invalid_cmd_i) begin
        nxt_state.rp_busy = 1'b1;
        nxt_state.rp_inv = !configuration_query_i;
        nxt_state.rp_val = state_ff.cfg;
        nxt_state.rp_idx = 4'h0;
        nxt_state.rp_lead = 1'b1;
      end
    end
    if (!state_ff.rp_valid || reply_ready_i) begin
      nxt_state.rp_valid = 1'b0;
      if (state_ff.rp_busy) begin
        ch = reply_char(state_ff.rp_idx, state_ff.rp_inv, state_ff.rp_val);
        nxt_state.rp_idx = state_ff.rp_idx + 4'h1;
        if (state_ff.rp_idx == 4'h9) begin
          nxt_state.rp_busy = 1'b0;
        end
        if (state_ff.rp_inv && state_ff.rp_idx == 4'h1) begin
          // Invalid reply skips to its line end
          nxt_state.rp_idx = 4'h8;
        end
        // Leading zeros suppressed, last digit always sent
        if (state_ff.rp_idx >= 4'h3 && state_ff.rp_idx <= 4'h6 && state_ff.rp_lead && ch == `CHP_CH_ZERO) begin
          nxt_state.rp_valid = 1'b0;
        end else begin
          nxt_state.rp_valid = 1'b1;
          nxt_state.rp_data = ch;
          if (state_ff.rp_idx >= 4'h3) begin
            nxt_state.rp_lead = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
      state_ff.st <= chp_pkg::DEV_IDLE;
      state_ff.cs_sync <= 2'h3;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flops
  assign link.sck = state_ff.sck;
  assign link.sdo = state_ff.sdo;
  assign reply_data_o = state_ff.rp_data;
  assign reply_valid_o = state_ff.rp_valid;
  assign reply_busy_o = state_ff.rp_busy;
  assign config_status_o = state_ff.cfg;
endmodule

/* chp_host.sv */
// Host controller end: runs one-command serial sessions on the compass link.
// Assumes sck and sdo come from another clock domain; software uses AXI4-Lite.
`timescale 1ns/10ps
`include "chp_defs.svh"
module chp_host (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Link to the compass
  chp_link_if.host         link,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Interrupt
  output logic             irq_o
);
  chp_pkg::chp_hst_state_t state_ff;
  chp_pkg::chp_hst_state_t nxt_state;

  // ==========================================================================
  // Next state
  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    logic [1:0] ev;
    logic [31:0] rd;
    nxt_state = state_ff;
    ev = 2'h0;
    rd = 32'h0000_0000;
    // Edge detect works off the second stage only
    nxt_state.sck_sync = {state_ff.sck_sync[0], link.sck};
    nxt_state.sck_prev = state_ff.sck_sync[1];
    nxt_state.sdo_sync = {state_ff.sdo_sync[0], link.sdo};
    rise = state_ff.sck_sync[1] && !state_ff.sck_prev;
    fall = !state_ff.sck_sync[1] && state_ff.sck_prev;
    byte_in = {state_ff.rx[6:0], state_ff.sdo_sync[1]};

    // Serial session
    unique case (state_ff.st)
      chp_pkg::HST_IDLE: begin
        nxt_state.cs_n = 1'b1;
        nxt_state.sdi = 1'b0;
      end
      chp_pkg::HST_RUN: begin
        if (rise) begin
          // Compass data taken at rising edge
          nxt_state.rx = byte_in;
          nxt_state.bitn = state_ff.bitn + 3'h1;
          if (state_ff.bitn == 3'h7) begin
            nxt_state.byten = state_ff.byten + 2'h1;
            if (state_ff.byten == 2'h0) begin
              nxt_state.echo = byte_in;
            end else if (state_ff.byten == 2'h1) begin
              nxt_state.data = state_ff.is_head ? {byte_in, 8'h00} : {8'h00, byte_in};
              if (!state_ff.is_head && byte_in == `CHP_CH_ERR) begin
                ev[`CHP_IRQ_ERR_BIT] = 1'b1;
              end
            end else begin
              nxt_state.data = {state_ff.data[15:8], byte_in};
            end
            if (state_ff.byten == (state_ff.is_head ? 2'h2 : 2'h1)) begin
              nxt_state.st = chp_pkg::HST_END;
            end
          end
        end
        if (fall) begin
          // Next command bit after falling edge
          nxt_state.sdi = state_ff.cmd_sh[7];
          nxt_state.cmd_sh = {state_ff.cmd_sh[6:0], 1'b0};
        end
      end
      chp_pkg::HST_END: begin
        // Release select once the last pulse is over
        if (fall) begin
          nxt_state.cs_n = 1'b1;
          nxt_state.sdi = 1'b0;
          nxt_state.st = chp_pkg::HST_IDLE;
          ev[`CHP_IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: nxt_state.st = chp_pkg::HST_IDLE;
    endcase

    // Write channel: address and data taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_state.aw_have = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_state.w_have = 1'b1;
      nxt_state.w_data = s_axi_wdata_i;
      nxt_state.w_strb = s_axi_wstrb_i;
    end
    if (state_ff.bvalid && s_axi_bready_i) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.aw_have && state_ff.w_have) begin
      nxt_state.aw_have = 1'b0;
      nxt_state.w_have = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `CHP_RESP_OKAY;
      unique case (state_ff.aw_addr)
        `CHP_REG_CMD: begin
          // Command goes out with the start character; select held whole session
          if (state_ff.st == chp_pkg::HST_IDLE && state_ff.w_strb[0]) begin
            nxt_state.cs_n = 1'b0;
            nxt_state.sdi = state_ff.w_data[7];
            nxt_state.cmd_sh = {state_ff.w_data[6:0], 1'b0};
            nxt_state.is_head = chp_pkg::chp_is_heading(state_ff.w_data[7:0]);
            nxt_state.bitn = 3'h0;
            nxt_state.byten = 2'h0;
            nxt_state.st = chp_pkg::HST_RUN;
          end
        end
        `CHP_REG_IRQ_STAT: begin
          if (state_ff.w_strb[0]) begin
            nxt_state.irq_stat = state_ff.irq_stat & ~state_ff.w_data[1:0];
          end
        end
        `CHP_REG_IRQ_MASK: begin
          if (state_ff.w_strb[0]) begin
            nxt_state.irq_mask = state_ff.w_data[1:0];
          end
        end
        `CHP_REG_STATUS, `CHP_REG_DATA: nxt_state.bresp = `CHP_RESP_OKAY;
        default: nxt_state.bresp = `CHP_RESP_SLVERR;
      endcase
    end
    // Events land after the clear so a simultaneous one survives
    nxt_state.irq_stat = nxt_state.irq_stat | ev;

    // Read channel
    if (state_ff.rvalid && s_axi_rready_i) begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = `CHP_RESP_OKAY;
      unique case (s_axi_araddr_i)
        `CHP_REG_CMD:      rd = {24'h000000, state_ff.cmd_sh};
        `CHP_REG_STATUS:   rd = {16'h0000, state_ff.echo, 7'h00, state_ff.st != chp_pkg::HST_IDLE};
        `CHP_REG_DATA:     rd = {16'h0000, state_ff.data};
        `CHP_REG_IRQ_STAT: rd = {30'h00000000, state_ff.irq_stat};
        `CHP_REG_IRQ_MASK: rd = {30'h00000000, state_ff.irq_mask};
        default: begin
          rd = 32'h0000_0000;
          nxt_state.rresp = `CHP_RESP_SLVERR;
        end
      endcase
      nxt_state.rdata = rd;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
      state_ff.st <= chp_pkg::HST_IDLE;
      state_ff.cs_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Handshake outputs; the host never touches the clock line
  assign s_axi_awready_o = !state_ff.aw_have && !state_ff.bvalid;
  assign s_axi_wready_o = !state_ff.w_have && !state_ff.bvalid;
  assign s_axi_bvalid_o = state_ff.bvalid;
  assign s_axi_bresp_o = state_ff.bresp;
  assign s_axi_arready_o = !state_ff.rvalid;
  assign s_axi_rvalid_o = state_ff.rvalid;
  assign s_axi_rdata_o = state_ff.rdata;
  assign s_axi_rresp_o = state_ff.rresp;
  // Host drives only select and command data
  assign link.cs_n = state_ff.cs_n;
  assign link.sdi = state_ff.sdi;
  assign irq_o = |(state_ff.irq_stat & state_ff.irq_mask);
endmodule

/* chp_link_assertions.sv */
// Checker for the serial link between the compass end and the host end.
// Assumes one shared core clock at 25 MHz sampling the link signals.
`timescale 1ns/10ps
`include "chp_defs.svh"
module chp_link_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sck,
  input wire logic sdo
);
  localparam logic [7:0] START_CH = `CHP_CH_START;
  logic [10:0] hi_ff;
  logic [10:0] lo_ff;
  logic [10:0] sel_ff;
  logic [4:0]  fall_ff;
  logic        sck_ff;
  logic        seen_ff;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Phase counters; select count saturates so long holds never wrap
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {hi_ff, lo_ff, sel_ff, fall_ff, sck_ff, seen_ff} <= '0;
    end else begin
      hi_ff   <= sck ? hi_ff + 11'h1 : 11'h0;
      lo_ff   <= sck ? 11'h0 : lo_ff + 11'h1;
      sel_ff  <= cs_n ? 11'h0 : sel_ff + {10'h0, sel_ff != 11'h7ff};
      fall_ff <= cs_n ? 5'h0 : fall_ff + {4'h0, sck_ff & !sck};
      seen_ff <= !cs_n & (seen_ff | (sck_ff & !sck));
      sck_ff  <= sck;
    end
  end
  // ==========================================
  // Link properties
  property p_idle; cs_n |-> !sck; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle low");
  property p_high; $fell(sck) |-> hi_ff == 11'd400; endproperty
  a_high: assert property (p_high) else $error("clock high time wrong");
  property p_low; $rose(sck) && seen_ff |-> lo_ff == 11'd550 || lo_ff == 11'd1250; endproperty
  a_low: assert property (p_low) else $error("clock low time or byte gap wrong");
  property p_hold; sck |-> $stable(sdo); endproperty
  a_hold: assert property (p_hold) else $error("data changed while clock high");
  property p_start; $rose(sck) && fall_ff < 5'd8 |-> sdo == START_CH[3'd7 - fall_ff[2:0]]; endproperty
  a_start: assert property (p_start) else $error("start byte wrong");
  property p_csmin; $rose(cs_n) |-> sel_ff >= 11'd500; endproperty
  a_csmin: assert property (p_csmin) else $error("select held too short");
  property p_quiet; !cs_n && sel_ff < 11'd1000 |-> !sck; endproperty
  a_quiet: assert property (p_quiet) else $error("clock before select time");
  property p_frame; $rose(cs_n) |-> fall_ff == 5'd16 || fall_ff == 5'd24; endproperty
  a_frame: assert property (p_frame) else $error("session pulse count wrong");
  c_two: cover property ($rose(cs_n) && fall_ff == 5'd16);
  c_three: cover property ($rose(cs_n) && fall_ff == 5'd24);
  c_gap: cover property ($rose(sck) && lo_ff == 11'd1250);
endmodule

/* tb_top.sv */
// Bench joining the compass end and the host end across the link.
// Assumes software access over AXI4-Lite and one 25 MHz clock.
`timescale 1ns/10ps
`include "chp_defs.svh"
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, rbyte, c;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        irq, awrdy, wrdy, arrdy, bvalid, rvalid, rvld, busy;
  logic [1:0]  bresp, rresp, rs;
  logic [11:0] heading = 12'h0;
  logic        split = 1'b0, m10 = 1'b0, m20 = 1'b0, hsel = 1'b0, msel = 1'b0;
  logic        query = 1'b0, inval = 1'b0, rrdy = 1'b1;
  logic [15:0] cfg;
  int          err_total = 0, checks_done = 0, cyc = 0;
  chp_link_if link ();
  chp_dev i_chp_dev (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link), .heading_i(heading),
    .separate_filter_select_i(split), .temp_below_m10_i(m10), .temp_below_m20_i(m20),
    .heading_out_sel_i(hsel), .mag_out_sel_i(msel), .configuration_query_i(query),
    .invalid_cmd_i(inval), .reply_ready_i(rrdy), .reply_data_o(rbyte), .reply_valid_o(rvld),
    .reply_busy_o(busy), .config_status_o(cfg));
  chp_host i_chp_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
    .irq_o(irq));
  chp_link_assertions i_chp_link_assertions (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n(link.cs_n),
    .sdi(link.sdi), .sck(link.sck), .sdo(link.sdo));
  // ==========================================
  // Clock and hang guard
  initial forever #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Write: both beats offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    {ta, tw} = 2'b00;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'b11;
    while (!(ta && tw)) begin
      @(posedge clock_i);
      if (awvalid && awrdy === 1'b1) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wrdy === 1'b1) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clock_i); while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock_i); while (arrdy !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (rvalid !== 1'b1);
    {rd, rs} = {rdata, rresp};
  endtask
  // Expected word: bit 5 fixed, sticky temperature bits given by a
  function automatic logic [15:0] ecw(input logic a);
    return {5'h0, split, a, a, 2'h0, 1'b1, 1'b0, hsel, 1'b0, msel, 1'b0};
  endfunction
  // Collect reply bytes while the consumer stalls at random
  task automatic rep(input string t);
    logic hit;
    for (int i = 0; i < t.len(); i++) begin
      do begin
        @(posedge clock_i);
        hit = rvld === 1'b1 && rrdy;
        rrdy <= 1'($urandom);
      end while (!hit);
      chk(rbyte, t[i]);
    end
  endtask
  task automatic ask(input logic q);
    repeat (3) @(posedge clock_i);
    {query, inval} <= {q, !q};
    @(posedge clock_i);
    {query, inval} <= 2'b00;
    @(posedge clock_i);
    chk(busy, 1'b1);
  endtask
  task automatic sess(input logic [7:0] cmd, input logic [31:0] ed, input logic [31:0] es);
    axw(`CHP_REG_IRQ_MASK, 32'h1);
    axw(`CHP_REG_CMD, {24'h0, cmd});
    do @(posedge clock_i); while (irq !== 1'b1);
    axr(`CHP_REG_DATA);
    chk(rd, ed);
    axr(`CHP_REG_STATUS);
    chk(rd[15:8], `CHP_CH_START);
    axr(`CHP_REG_IRQ_STAT);
    chk(rd, es);
    axw(`CHP_REG_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    axw(`CHP_REG_IRQ_STAT, 32'h3);
    axr(`CHP_REG_IRQ_STAT);
    chk(rd, 32'h0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'ha2d83d6c));
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    axr(`CHP_REG_IRQ_MASK);
    chk(rd, 32'h0);
    axr(8'h14);
    chk(rs, `CHP_RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      {split, hsel, msel} <= 3'($urandom);
      {m10, m20} <= {2{k[0]}};
      @(posedge clock_i);
      {m10, m20} <= 2'b00;
      repeat (3) @(posedge clock_i);
      chk(cfg, ecw(k[0]));
      ask(1'b1);
      rep($sformatf("#D=%0d\r\n", ecw(k[0])));
    end
    ask(1'b0);
    rep("#I\r\n");
    heading <= 12'($urandom_range(3599));
    @(posedge clock_i);
    sess(`CHP_CH_HUP, {20'h0, heading}, 32'h1);
    heading <= 12'd3599;
    @(posedge clock_i);
    sess(`CHP_CH_HLO, 32'd3599, 32'h1);
    c = 8'($urandom);
    if (c == `CHP_CH_HUP || c == `CHP_CH_HLO) c = 8'h21;
    sess(c, {24'h0, `CHP_CH_ERR}, 32'h3);
    final_report();
  end
endmodule
